/* File: design/rpi_defs.svh */
// Constants for the RGB pixel input port and its host
`ifndef RPI_DEFS_SVH
`define RPI_DEFS_SVH
// ----------------------------------------
// Mode pin codes and color formats
// ----------------------------------------
`define RPI_MODE1 2'b10
`define RPI_MODE2 2'b11
`define RPI_FMT16 8'h50
`define RPI_FMT18 8'h60
`define RPI_FMT6 8'hE0
`define RPI_FMT6_XFERS 3
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define RPI_H_ACTIVE 240
`define RPI_V_ACTIVE 320
`define RPI_DIV_HALF 1
// ----------------------------------------
// Host register offsets
// ----------------------------------------
`define RPI_OFS_CTRL 8'h00
`define RPI_OFS_HTIM 8'h04
`define RPI_OFS_VTIM 8'h08
`define RPI_OFS_SIZE 8'h0C
`define RPI_OFS_COLOR 8'h10
`define RPI_OFS_STAT 8'h14
// ----------------------------------------
// Host field positions
// ----------------------------------------
`define RPI_CTRL_EN 0
`define RPI_CTRL_MODE 2:1
`define RPI_CTRL_FMT 15:8
`define RPI_TIM_SYNC 7:0
`define RPI_TIM_BACK 15:8
`define RPI_TIM_FRONT 23:16
`define RPI_SIZE_H 9:0
`define RPI_SIZE_V 25:16
// ----------------------------------------
// Host reset values
// ----------------------------------------
`define RPI_RST_CTRL 16'h6004
`define RPI_RST_HTIM 24'h040402
`define RPI_RST_VTIM 24'h020201
`define RPI_RST_SIZE 26'h14000F0
`endif

/* File: design/rpi_device.sv */
// Receive end of the RGB pixel input port, on the pixel clock
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "rpi_defs.svh"
module rpi_device
  import rpi_pkg::*;
#(
  parameter int H_ACTIVE = `RPI_H_ACTIVE,
  parameter int V_ACTIVE = `RPI_V_ACTIVE
)
(
  rpi_video_if.device vid,
  input wire logic rst_in,
  input wire logic power_ready_in,
  input wire logic [7:0] color_format_in,
  input wire logic [7:0] horiz_back_porch_in,
  input wire logic [7:0] vert_back_porch_in,
  output logic pixel_valid_out,
  output logic [17:0] pixel_out,
  output logic [8:0] pixel_x_out,
  output logic [8:0] pixel_y_out,
  output logic frame_start_out,
  output logic format_error_out,
  output logic video_active_out
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  generate
    if (H_ACTIVE < 1 || H_ACTIVE > 510 || V_ACTIVE < 1 || V_ACTIVE > 510)
    begin : g_bad_size
      $error("rpi_device: active size out of range");
    end
  endgenerate

  localparam logic [8:0] H_ACT = 9'(H_ACTIVE);
  localparam logic [9:0] V_ACT = 10'(V_ACTIVE);

  rpi_dev_state_t r;
  rpi_dev_state_t n;
  rpi_fmt_t fmt;
  logic [17:0] assembled;
  logic m1, m2, run, vs_fall, hs_fall, win, take;
  logic [11:0] hcnt_c;
  logic [9:0] line_c, line_rel;
  logic [8:0] px_c, py_c;
  logic [1:0] ph_c;

  // ----------------------------------------
  // Pixel assembly
  // ----------------------------------------
  rpi_pix_unpack u_rpi_pix_unpack (
    .fmt_in(fmt),
    .bus_in(r.data_s),
    .red_in(r.red_h),
    .grn_in(r.grn_h),
    .pixel_out(assembled)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = r;
    // Input capture on the pixel clock
    n.vs_s = vid.frame_sync_n;
    n.hs_s = vid.line_sync_n;
    n.de_s = vid.data_enable;
    n.data_s = vid.video_data_bus;
    n.vs_d = r.vs_s;
    n.hs_d = r.hs_s;
    // Static settings through two stages
    n.pwr_m = power_ready_in;
    n.pwr_q = r.pwr_m;
    n.mode_m = vid.video_mode_pins;
    n.mode_q = r.mode_m;
    n.fmt_m = color_format_in;
    n.fmt_q = r.fmt_m;
    n.hbp_m = horiz_back_porch_in;
    n.hbp_q = r.hbp_m;
    n.vbp_m = vert_back_porch_in;
    n.vbp_q = r.vbp_m;
    n.valid = 1'b0;
    n.fstart = 1'b0;

    fmt = rpi_fmt_decode(r.fmt_q);
    m1 = (r.mode_q == `RPI_MODE1);
    m2 = (r.mode_q == `RPI_MODE2);
    run = r.pwr_q && (m1 || m2) && (fmt != FMT_BAD);
    vs_fall = r.vs_d && !r.vs_s;
    hs_fall = r.hs_d && !r.hs_s;

    // Position counters
    if (hs_fall)
      hcnt_c = 12'h000;
    else if (r.hcnt == 12'hFFF)
      hcnt_c = r.hcnt;
    else
      hcnt_c = r.hcnt + 12'h001;
    if (vs_fall)
      line_c = 10'h000;
    else if (hs_fall && r.line != 10'h3FF)
      line_c = r.line + 10'h001;
    else
      line_c = r.line;
    px_c = hs_fall ? 9'h000 : r.px;
    ph_c = hs_fall ? 2'b00 : r.phase;
    if (vs_fall)
      py_c = 9'h000;
    else if (hs_fall && r.px != 9'h000 && r.py != 9'h1FF)
      py_c = r.py + 9'h001;
    else
      py_c = r.py;

    // Porch window for mode 2
    line_rel = line_c - {2'b00, r.vbp_q};
    win = (line_c >= {2'b00, r.vbp_q}) && (line_rel < V_ACT) &&
          (hcnt_c >= {4'h0, r.hbp_q}) && (px_c < H_ACT);
    if (m2)
      py_c = line_rel[8:0];

    take = r.in_frame && !r.lost && (m1 ? r.de_s : win);

    // Mode 1 timing outside range drops input until next frame
    if (take && m1 && (px_c >= H_ACT || {1'b0, py_c} >= V_ACT))
    begin
      n.lost = 1'b1;
      take = 1'b0;
    end

    if (take)
    begin
      if (fmt == FMT_6 && ph_c == 2'd0)
      begin
        n.red_h = r.data_s[7:2];
        ph_c = 2'd1;
      end
      else if (fmt == FMT_6 && ph_c == 2'd1)
      begin
        n.grn_h = r.data_s[7:2];
        ph_c = 2'd2;
      end
      else
      begin
        n.valid = 1'b1;
        n.pixel = assembled;
        n.x = px_c;
        n.y = py_c;
        px_c = px_c + 9'h001;
        ph_c = 2'd0;
      end
    end

    n.hcnt = hcnt_c;
    n.line = line_c;
    n.px = px_c;
    n.py = py_c;
    n.phase = ph_c;

    // Frame lock
    if (!run)
      n.in_frame = 1'b0;
    else if (vs_fall)
    begin
      n.in_frame = 1'b1;
      n.lost = 1'b0;
      n.fstart = 1'b1;
    end
    n.ferr = (fmt == FMT_BAD);
    n.active = n.in_frame && !n.lost;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge vid.pixel_clock)
  begin
    if (rst_in)
    begin
      r <= '0;
      r.vs_s <= 1'b1;
      r.hs_s <= 1'b1;
      r.vs_d <= 1'b1;
      r.hs_d <= 1'b1;
    end
    else
      r <= n;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pixel_valid_out = r.valid;
  assign pixel_out = r.pixel;
  assign pixel_x_out = r.x;
  assign pixel_y_out = r.y;
  assign frame_start_out = r.fstart;
  assign format_error_out = r.ferr;
  assign video_active_out = r.active;
endmodule : rpi_device

/* File: design/rpi_host.sv */
// Host controller end: timing generator with APB registers
`timescale 1ns/100ps
`include "rpi_defs.svh"
module rpi_host
  import rpi_pkg::*;
#(
  parameter int DIV_HALF = `RPI_DIV_HALF
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  rpi_video_if.host vid
);
  generate
    if (DIV_HALF < 1 || DIV_HALF > 255)
    begin : g_bad_div
      $error("rpi_host: DIV_HALF out of range");
    end
  endgenerate

  localparam logic [7:0] DIV_END = 8'(DIV_HALF - 1);

  rpi_host_state_t r;
  rpi_host_state_t n;
  rpi_fmt_t fmt;
  logic acc, act, tick, fall;
  logic [11:0] hlen;
  logic [9:0] vlen;
  logic [5:0] comp;

  always_comb
  begin
    n = r;
    // ----------------------------------------
    // APB slave: one wait state per access
    // ----------------------------------------
    acc = psel_in && penable_in;
    n.pready = acc && !r.pready;
    n.pslverr = 1'b0;
    if (acc && !r.pready)
    begin
      n.prdata = 32'h00000000;
      unique case (paddr_in)
        `RPI_OFS_CTRL: n.prdata = {16'h0000, r.ctrl};
        `RPI_OFS_HTIM: n.prdata = {8'h00, r.htim};
        `RPI_OFS_VTIM: n.prdata = {8'h00, r.vtim};
        `RPI_OFS_SIZE: n.prdata = {6'h00, r.size};
        `RPI_OFS_COLOR: n.prdata = {14'h0000, r.color};
        `RPI_OFS_STAT: n.prdata = {15'h0000, r.vst == PH_ACT, r.frames};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (acc && r.pready && pwrite_in)
    begin
      unique case (paddr_in)
        `RPI_OFS_CTRL: n.ctrl = pwdata_in[15:0];
        `RPI_OFS_HTIM: n.htim = pwdata_in[23:0];
        `RPI_OFS_VTIM: n.vtim = pwdata_in[23:0];
        `RPI_OFS_SIZE: n.size = pwdata_in[25:0];
        `RPI_OFS_COLOR: n.color = pwdata_in[17:0];
        default: n.pslverr = 1'b0;
      endcase
    end
    n.mode_o = r.ctrl[`RPI_CTRL_MODE];

    // ----------------------------------------
    // Pixel clock divider, never stopped
    // ----------------------------------------
    tick = (r.div == DIV_END);
    n.div = tick ? 8'h00 : r.div + 8'h01;
    if (tick)
      n.pclk = !r.pclk;
    fall = tick && r.pclk;

    // ----------------------------------------
    // Frame timing, pins change on falling edge while enabled with a good format
    // ----------------------------------------
    fmt = rpi_fmt_decode(r.ctrl[`RPI_CTRL_FMT]);
    act = (r.hst == PH_ACT) && (r.vst == PH_ACT);
    unique case (r.phase)
      2'd0: comp = r.color[17:12];
      2'd1: comp = r.color[11:6];
      default: comp = r.color[5:0];
    endcase
    unique case (r.hst)
      PH_SYNC: hlen = {4'h0, r.htim[`RPI_TIM_SYNC]};
      PH_BACK: hlen = {4'h0, r.htim[`RPI_TIM_BACK]};
      PH_ACT: hlen = (fmt == FMT_6) ? 12'(r.size[`RPI_SIZE_H] * `RPI_FMT6_XFERS) : {2'b00, r.size[`RPI_SIZE_H]};
      PH_FRONT: hlen = {4'h0, r.htim[`RPI_TIM_FRONT]};
    endcase
    unique case (r.vst)
      PH_SYNC: vlen = {2'b00, r.vtim[`RPI_TIM_SYNC]};
      PH_BACK: vlen = {2'b00, r.vtim[`RPI_TIM_BACK]};
      PH_ACT: vlen = r.size[`RPI_SIZE_V];
      PH_FRONT: vlen = {2'b00, r.vtim[`RPI_TIM_FRONT]};
    endcase
    if (!r.ctrl[`RPI_CTRL_EN] || fmt == FMT_BAD)
    begin
      n.hst = PH_SYNC;
      n.vst = PH_SYNC;
      n.hcnt = 12'h000;
      n.vcnt = 10'h000;
      n.phase = 2'd0;
      n.hs_n = 1'b1;
      n.vs_n = 1'b1;
      n.de = 1'b0;
      n.data = 18'h00000;
    end
    else if (fall)
    begin
      n.hs_n = (r.hst != PH_SYNC);
      n.vs_n = (r.vst != PH_SYNC);
      n.de = act;
      n.data = 18'h00000;
      if (act)
      begin
        unique case (fmt)
          FMT_16: n.data = {r.color[17:13], 1'b0, r.color[11:6], r.color[5:1], 1'b0};
          FMT_18: n.data = r.color;
          FMT_6: n.data = {10'h000, comp, 2'b00};
          FMT_BAD: n.data = 18'h00000;
        endcase
        n.phase = (fmt == FMT_6 && r.phase != 2'd2) ? r.phase + 2'd1 : 2'd0;
      end
      n.hcnt = r.hcnt + 12'h001;
      if (n.hcnt >= hlen)
      begin
        n.hcnt = 12'h000;
        n.hst = rpi_phase_t'(r.hst + 2'd1);
        n.phase = 2'd0;
        if (r.hst == PH_FRONT)
        begin
          n.vcnt = r.vcnt + 10'h001;
          if (n.vcnt >= vlen)
          begin
            n.vcnt = 10'h000;
            n.vst = rpi_phase_t'(r.vst + 2'd1);
            if (r.vst == PH_FRONT)
              n.frames = r.frames + 16'h0001;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      r <= '0;
      r.ctrl <= `RPI_RST_CTRL;
      r.htim <= `RPI_RST_HTIM;
      r.vtim <= `RPI_RST_VTIM;
      r.size <= `RPI_RST_SIZE;
      r.hs_n <= 1'b1;
      r.vs_n <= 1'b1;
    end
    else
      r <= n;
  end

  assign pready_out = r.pready;
  assign pslverr_out = r.pslverr;
  assign prdata_out = r.prdata;
  assign vid.pixel_clock = r.pclk;
  assign vid.frame_sync_n = r.vs_n;
  assign vid.line_sync_n = r.hs_n;
  assign vid.data_enable = r.de;
  assign vid.video_data_bus = r.data;
  assign vid.video_mode_pins = r.mode_o;
endmodule : rpi_host

/* File: design/rpi_pix_unpack.sv */
// Bus word to 18-bit pixel assembly per color format
`timescale 1ns/100ps
module rpi_pix_unpack
  import rpi_pkg::*;
(
  input wire rpi_fmt_t fmt_in,
  input wire logic [17:0] bus_in,
  input wire logic [5:0] red_in,
  input wire logic [5:0] grn_in,
  output logic [17:0] pixel_out
);
  always_comb
  begin
    unique case (fmt_in)
      FMT_16: pixel_out = {bus_in[17:13], bus_in[17], bus_in[11:6], bus_in[5:1], bus_in[5]};
      FMT_18: pixel_out = bus_in;
      FMT_6: pixel_out = {red_in, grn_in, bus_in[7:2]};
      FMT_BAD: pixel_out = 18'h00000;
    endcase
  end
endmodule : rpi_pix_unpack

/* File: design/rpi_pkg.sv */
// Types shared by both ends of the RGB pixel input port
`include "rpi_defs.svh"
package rpi_pkg;
  typedef enum logic [1:0] {FMT_16 = 2'b00, FMT_18 = 2'b01, FMT_6 = 2'b10, FMT_BAD = 2'b11} rpi_fmt_t;
  typedef enum logic [1:0] {PH_SYNC = 2'b00, PH_BACK = 2'b01, PH_ACT = 2'b10, PH_FRONT = 2'b11} rpi_phase_t;

  typedef struct packed {
    logic vs_s, hs_s, de_s, vs_d, hs_d;
    logic [17:0] data_s;
    logic pwr_m, pwr_q;
    logic [1:0] mode_m, mode_q;
    logic [7:0] fmt_m, fmt_q, hbp_m, hbp_q, vbp_m, vbp_q;
    logic in_frame, lost;
    logic [11:0] hcnt;
    logic [9:0] line;
    logic [8:0] px, py;
    logic [1:0] phase;
    logic [5:0] red_h, grn_h;
    logic valid, fstart, ferr, active;
    logic [17:0] pixel;
    logic [8:0] x, y;
  } rpi_dev_state_t;

  typedef struct packed {
    logic pready, pslverr;
    logic [31:0] prdata;
    logic [15:0] ctrl;
    logic [23:0] htim, vtim;
    logic [25:0] size;
    logic [17:0] color;
    logic [15:0] frames;
    logic [7:0] div;
    logic pclk;
    rpi_phase_t hst, vst;
    logic [11:0] hcnt;
    logic [9:0] vcnt;
    logic [1:0] phase;
    logic hs_n, vs_n, de;
    logic [17:0] data;
    logic [1:0] mode_o;
  } rpi_host_state_t;

  function automatic rpi_fmt_t rpi_fmt_decode(input logic [7:0] code);
    rpi_fmt_t f;
    f = FMT_BAD;
    if (code == `RPI_FMT16) f = FMT_16;
    if (code == `RPI_FMT18) f = FMT_18;
    if (code == `RPI_FMT6) f = FMT_6;
    return f;
  endfunction : rpi_fmt_decode
endpackage : rpi_pkg

/* File: design/rpi_video_if.sv */
// Video link between host controller and pixel input port
`timescale 1ns/100ps
interface rpi_video_if;
  logic pixel_clock;
  logic frame_sync_n;
  logic line_sync_n;
  logic data_enable;
  logic [17:0] video_data_bus;
  logic [1:0] video_mode_pins;

  modport host (output pixel_clock, frame_sync_n, line_sync_n, data_enable, video_data_bus, video_mode_pins);
  modport device (input pixel_clock, frame_sync_n, line_sync_n, data_enable, video_data_bus, video_mode_pins);
endinterface : rpi_video_if

/* File: verif/rgb_pixel_input_port_tb_top.sv */
// Testbench joining host and receive end over the video link
`timescale 1ns/100ps
`include "rpi_defs.svh"
module rgb_pixel_input_port_tb_top;
  localparam int H = 8;
  localparam int V = 4;
  localparam logic [17:0] COLOR = 18'h2C6B5;
  logic clk_in = 1'b0;
  logic host_rst = 1'b1;
  logic dev_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pwr_ok = 1'b0, mon_on = 1'b0;
  logic [7:0] paddr = 8'h00, fmt = 8'h60;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, pv, fs, fe, va;
  logic [31:0] prdata;
  logic [17:0] pix;
  logic [17:0] exp_pix = 18'h0;
  logic [8:0] px, py;
  int fail_count = 0, num_checks = 0, pix_cnt = 0;
  rpi_video_if vif();
  always #20 clk_in = ~clk_in;
  rpi_host #(.DIV_HALF(1)) u_rpi_host (.clk_in(clk_in), .rst_in(host_rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .vid(vif.host));
  rpi_device #(.H_ACTIVE(H), .V_ACTIVE(V)) u_rpi_device (.vid(vif.device), .rst_in(dev_rst),
    .power_ready_in(pwr_ok), .color_format_in(fmt), .horiz_back_porch_in(8'h06), .vert_back_porch_in(8'h03),
    .pixel_valid_out(pv), .pixel_out(pix), .pixel_x_out(px), .pixel_y_out(py), .frame_start_out(fs),
    .format_error_out(fe), .video_active_out(va));
  rpi_link_props #(.H_ACTIVE(H), .V_ACTIVE(V)) u_rpi_link_props (.pixel_clock(vif.pixel_clock),
    .rst_in(dev_rst), .frame_sync_n(vif.frame_sync_n), .data_enable(vif.data_enable),
    .video_data_bus(vif.video_data_bus), .video_mode_pins(vif.video_mode_pins), .power_ready_in(pwr_ok),
    .color_format_in(fmt), .pixel_valid_out(pv), .pixel_out(pix), .pixel_x_out(px), .pixel_y_out(py),
    .frame_start_out(fs), .format_error_out(fe), .video_active_out(va));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // Answer taken at the rising edge that sees pready high
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("bus answer", {31'h0, pready}, 32'h1);
  endtask : apb
  task automatic setup(input logic [1:0] m, input logic [7:0] f);
    logic [31:0] q;
    logic e;
    apb(1'b1, `RPI_OFS_CTRL, {16'h0000, f, 5'h00, m, 1'b1}, q, e);
    fmt <= f;
  endtask : setup
  task automatic wait_frame;
    int n;
    n = 0;
    do
    begin
      @(negedge vif.pixel_clock);
      n++;
    end
    while (fs !== 1'b1 && n < 1000);
    check("frame start", {31'h0, fs}, 32'h1);
  endtask : wait_frame
  task automatic frame_check(input string what, input logic [17:0] ex);
    wait_frame();
    wait_frame();
    exp_pix = ex;
    pix_cnt = 0;
    mon_on = 1'b1;
    wait_frame();
    mon_on = 1'b0;
    check(what, pix_cnt, H * V);
  endtask : frame_check
  task automatic quiet(input string what);
    repeat (20) @(negedge vif.pixel_clock);
    pix_cnt = 0;
    mon_on = 1'b1;
    repeat (400) @(negedge vif.pixel_clock);
    mon_on = 1'b0;
    check(what, pix_cnt, 0);
  endtask : quiet
  always @(negedge vif.pixel_clock)
    if (mon_on && pv === 1'b1)
    begin
      check("pixel value", {14'h0, pix}, {14'h0, exp_pix});
      check("pixel x", {23'h0, px}, pix_cnt % H);
      check("pixel y", {23'h0, py}, pix_cnt / H);
      pix_cnt++;
    end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs;
    logic [31:0] q;
    logic e;
    logic [31:0] rv [4] = '{32'h6004, 32'h040402, 32'h020201, 32'h014000F0};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0, q, e);
      check("reset value", q, rv[i]);
    end
    apb(1'b1, 8'h18, 32'hFFFFFFFF, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    apb(1'b0, 8'h18, 32'h0, q, e);
    check("unmapped data", q, 32'h0);
    apb(1'b1, `RPI_OFS_SIZE, 32'h00040008, q, e);
    apb(1'b1, `RPI_OFS_COLOR, {14'h0, COLOR}, q, e);
  endtask : test_regs
  task automatic test_formats;
    logic [7:0] fl [3] = '{8'h60, 8'h50, 8'hE0};
    logic [17:0] c;
    for (int i = 0; i < 3; i++)
    begin
      c = COLOR;
      if (fl[i] == 8'h50)
        c = {c[17:13], c[17], c[11:6], c[5:1], c[5]};
      setup(2'b10, fl[i]);
      frame_check("format pixel count", c);
      check("format flag", {31'h0, fe}, 32'h0);
    end
  endtask : test_formats
  task automatic test_mode2;
    setup(2'b11, 8'h60);
    frame_check("porch window count", COLOR);
  endtask : test_mode2
  task automatic test_gates;
    setup(2'b10, 8'h60);
    fmt <= 8'h70;
    quiet("bad format pixels");
    check("format flag", {31'h0, fe}, 32'h1);
    fmt <= 8'h60;
    pwr_ok <= 1'b0;
    quiet("unpowered pixels");
    check("active unpowered", {31'h0, va}, 32'h0);
    pwr_ok <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      setup(2'(m), 8'h60);
      quiet("mode off pixels");
    end
  endtask : test_gates
  task automatic test_recover;
    logic [31:0] q;
    logic e;
    setup(2'b10, 8'h60);
    apb(1'b1, `RPI_OFS_SIZE, 32'h00040009, q, e);
    wait_frame();
    wait_frame();
    repeat (120) @(negedge vif.pixel_clock);
    check("active when lost", {31'h0, va}, 32'h0);
    apb(1'b1, `RPI_OFS_SIZE, 32'h00040008, q, e);
    frame_check("recovered count", COLOR);
    check("active again", {31'h0, va}, 32'h1);
  endtask : test_recover
  initial
  begin
    repeat (20) @(posedge clk_in);
    host_rst <= 1'b0;
    repeat (6) @(posedge clk_in);
    dev_rst <= 1'b0;
    pwr_ok <= 1'b1;
    test_regs();
    test_formats();
    test_mode2();
    test_gates();
    test_recover();
    print_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge clk_in);
    fail_count++;
    print_verdict();
  end
endmodule : rgb_pixel_input_port_tb_top

/* File: verif/rpi_link_props.sv */
// Checker for the video link and the receive end outputs
`timescale 1ns/100ps
module rpi_link_props
#(
  parameter int H_ACTIVE = 240,
  parameter int V_ACTIVE = 320
)
(
  input wire logic pixel_clock,
  input wire logic rst_in,
  input wire logic frame_sync_n,
  input wire logic data_enable,
  input wire logic [17:0] video_data_bus,
  input wire logic [1:0] video_mode_pins,
  input wire logic power_ready_in,
  input wire logic [7:0] color_format_in,
  input wire logic pixel_valid_out,
  input wire logic [17:0] pixel_out,
  input wire logic [8:0] pixel_x_out,
  input wire logic [8:0] pixel_y_out,
  input wire logic frame_start_out,
  input wire logic format_error_out,
  input wire logic video_active_out
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pixel_clock); endclocking
  default disable iff (rst_in);
  logic fmt_ok;
  assign fmt_ok = color_format_in inside {8'h50, 8'h60, 8'hE0};
  sequence s_pix_in;
    video_active_out && video_mode_pins == 2'b10 && $past(video_mode_pins, 4) == 2'b10 &&
      color_format_in == 8'h60 && $past(color_format_in, 4) == 8'h60 && data_enable && frame_sync_n;
  endsequence
  sequence s_pix_out;
    ##2 ((pixel_valid_out && pixel_out == $past(video_data_bus, 2)) || !video_active_out);
  endsequence
  mode1_pixel_a: assert property (s_pix_in |-> s_pix_out)
    else $error("mode 1 pixel not delivered");
  pixel_cause_a: assert property (pixel_valid_out && color_format_in == 8'h60 &&
    $past(video_mode_pins, 2) == 2'b10 && $past(video_mode_pins, 6) == 2'b10 |-> $past(data_enable, 2))
    else $error("pixel without data enable");
  format_bad_a: assert property (!fmt_ok [*6] |-> format_error_out)
    else $error("invalid format not flagged");
  format_good_a: assert property (fmt_ok [*6] |-> !format_error_out)
    else $error("valid format flagged");
  error_quiet_a: assert property (format_error_out && $past(format_error_out, 2) |-> !pixel_valid_out)
    else $error("pixel under invalid format");
  power_gate_a: assert property (!power_ready_in [*6] |-> !pixel_valid_out && !video_active_out)
    else $error("input live before power ready");
  frame_mark_a: assert property (frame_start_out |-> $past(frame_sync_n, 3) && !$past(frame_sync_n, 2))
    else $error("frame start without sync fall");
  pos_range_a: assert property (pixel_valid_out |-> pixel_x_out < H_ACTIVE && pixel_y_out < V_ACTIVE)
    else $error("pixel position out of range");
  x_step_a: assert property (pixel_valid_out && $past(pixel_valid_out) |->
    pixel_x_out == $past(pixel_x_out) + 9'h001)
    else $error("x does not step by one");
  pixel_hold_a: assert property (!pixel_valid_out |-> $stable(pixel_out))
    else $error("pixel changed without valid");
  mode_off_a: assert property (!video_mode_pins[1] [*6] |-> !pixel_valid_out)
    else $error("pixel with video mode off");
endmodule : rpi_link_props
